// ### scm_controller.sv
// Notes on behaviour
// - Debug select low or open routes the debug chain to the FPGA, high routes it here.
// - supplies_good is high only while every supply rail reports good.
// - A low external_reset_n holds the configuration restart line low.
// - aux_reset_n holds the restart line low exactly like external_reset_n, and high does nothing.
// - aux_reset_n resets the FPGA only and never touches any supply switch.
// - After power-up the restart line stays low until all rails have settled.
// - Both status lamps flash while the FPGA is unconfigured.
// - After configuration the status lamps follow the user design.
// - The external supply is switched onto the internal 3.3V rail only once the core rail is good.
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module scm_controller #(
  parameter int unsigned NUM_RAILS = 4,
  parameter int unsigned SETTLE_CYCLES = scm_pkg::SETTLE_CYCLES,
  parameter logic [31:0] FLASH_HALF_RESET = 32'(scm_pkg::FLASH_HALF_CYCLES)
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [NUM_RAILS-1:0] rail_good,
  input wire logic external_reset_n,
  input wire logic aux_reset_n,
  input wire logic debug_port_select,
  input wire logic fpga_config_done,
  input wire scm_pkg::scm_lamps_t user_status_lamps,
  output logic supplies_good,
  output logic fpga_config_restart_n,
  output logic rail_3v3_enable,
  output logic jtag_to_fpga_en,
  output logic jtag_to_ctrl_en,
  output logic status_lamp_green,
  output logic status_lamp_red,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import scm_pkg::*;

  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic ext_s;
  logic aux_s;
  logic dbg_s;
  scm_seq_t seq;
  logic [31:0] settle_cnt;
  logic [31:0] ctrl;
  logic [31:0] flash_half;
  logic [31:0] flash_cnt;
  logic flash;
  logic all_good;
  logic aw_got;
  logic w_got;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  scm_status_t status;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {external_reset_n, aux_reset_n, debug_port_select};
      sync_b <= sync_a;
    end
  end
  assign ext_s = sync_b[2];
  assign aux_s = sync_b[1];
  assign dbg_s = sync_b[0];
  assign all_good = &rail_good;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      jtag_to_fpga_en <= 1'b1;
      jtag_to_ctrl_en <= 1'b0;
    end else begin
      jtag_to_fpga_en <= !dbg_s;
      jtag_to_ctrl_en <= dbg_s;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      supplies_good <= 1'b0;
    end else begin
      supplies_good <= all_good;
    end
  end

  // 3.3V switch follows core rail only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rail_3v3_enable <= 1'b0;
    end else begin
      rail_3v3_enable <= rail_good[0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      seq <= SEQ_OFF;
      settle_cnt <= 32'h0;
    end else if (!all_good) begin
      seq <= SEQ_OFF;
      settle_cnt <= 32'h0;
    end else begin
      unique case (seq)
        SEQ_OFF: begin
          seq <= SEQ_SETTLE;
          settle_cnt <= 32'h0;
        end
        SEQ_SETTLE: begin
          if (settle_cnt >= SETTLE_CYCLES - 1) begin
            seq <= SEQ_RUN;
          end
          settle_cnt <= settle_cnt + 32'h1;
        end
        SEQ_RUN: begin
          seq <= SEQ_RUN;
        end
        default: begin
          seq <= SEQ_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fpga_config_restart_n <= 1'b0;
    end else begin
      fpga_config_restart_n <= (seq == SEQ_RUN) && ext_s && aux_s && !ctrl[CTRL_SOFT_RESTART];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flash_cnt <= 32'h0;
      flash <= 1'b0;
    end else if (fpga_config_done) begin
      flash_cnt <= 32'h0;
      flash <= 1'b0;
    end else if (flash_cnt >= flash_half) begin
      flash_cnt <= 32'h0;
      flash <= !flash;
    end else begin
      flash_cnt <= flash_cnt + 32'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status_lamp_green <= 1'b0;
      status_lamp_red <= 1'b0;
    end else if (fpga_config_done) begin
      status_lamp_green <= user_status_lamps.green;
      status_lamp_red <= user_status_lamps.red;
    end else begin
      status_lamp_green <= flash;
      status_lamp_red <= flash;
    end
  end

  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Write channel capture and response
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_got && w_got && !s_axi_bvalid) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == ADDR_CTRL || aw_addr == ADDR_FLASH ||
                        aw_addr == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register updates, byte lanes honoured
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
      flash_half <= FLASH_HALF_RESET;
    end else if (aw_got && w_got && !s_axi_bvalid) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb[b] && aw_addr == ADDR_CTRL) begin
          ctrl[b*8 +: 8] <= w_data[b*8 +: 8];
        end
        if (w_strb[b] && aw_addr == ADDR_FLASH) begin
          flash_half[b*8 +: 8] <= w_data[b*8 +: 8];
        end
      end
    end
  end

  always_comb begin
    status = '0;
    status.seq = seq;
    status.restart_n = fpga_config_restart_n;
    status.debug_sel = dbg_s;
    status.aux_n = aux_s;
    status.ext_n = ext_s;
    status.config_done = fpga_config_done;
    status.core_good = rail_good[0];
    status.supplies_good = supplies_good;
  end

  // Read channel
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_CTRL: s_axi_rdata <= {31'h0, ctrl[CTRL_SOFT_RESTART]};
        ADDR_FLASH: s_axi_rdata <= flash_half;
        ADDR_STATUS: s_axi_rdata <= status;
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  AST_JTAG_ROUTE: assert property (@(posedge clock) disable iff (!rst_n)
    dbg_s |=> (jtag_to_ctrl_en && !jtag_to_fpga_en))
    else $error("debug chain not routed to controller");
  AST_SUPPLIES_GOOD: assert property (@(posedge clock) disable iff (!rst_n)
    !all_good |=> !supplies_good)
    else $error("supplies_good high with a failed rail");
  AST_EXT_RESET: assert property (@(posedge clock) disable iff (!rst_n)
    !ext_s |=> !fpga_config_restart_n)
    else $error("external reset did not hold restart low");
  AST_AUX_RESET: assert property (@(posedge clock) disable iff (!rst_n)
    !aux_s |=> !fpga_config_restart_n)
    else $error("aux reset did not hold restart low");
  AST_AUX_NO_RAIL: assert property (@(posedge clock) disable iff (!rst_n)
    ($changed(aux_s) && $stable(rail_good[0])) |=> $stable(rail_3v3_enable))
    else $error("aux reset moved the supply switch");
  AST_SETTLE_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    (seq != SEQ_RUN) |=> !fpga_config_restart_n)
    else $error("restart released before supplies settled");
  AST_SETTLE_DONE: assert property (@(posedge clock) disable iff (!rst_n)
    (seq == SEQ_SETTLE && all_good && settle_cnt == SETTLE_CYCLES - 1) |=> seq == SEQ_RUN)
    else $error("settle end not reached on time");
  AST_FLASH: assert property (@(posedge clock) disable iff (!rst_n)
    (!fpga_config_done && flash_cnt >= flash_half) |=> flash != $past(flash))
    else $error("lamp flash did not toggle");
  AST_HANDOVER: assert property (@(posedge clock) disable iff (!rst_n)
    fpga_config_done |=> (status_lamp_green == $past(user_status_lamps.green) &&
                          status_lamp_red == $past(user_status_lamps.red)))
    else $error("lamps not handed to user design");
  AST_RAIL_3V3: assert property (@(posedge clock) disable iff (!rst_n)
    rail_3v3_enable |-> $past(rail_good[0]))
    else $error("3.3V switched on without core rail");
  AST_SYNC_PATH: assert property (@(posedge clock) disable iff (!rst_n)
    !external_reset_n [*3] |=> !fpga_config_restart_n)
    else $error("external reset not through synchroniser in time");
endmodule
`default_nettype wire

// ### scm_pkg.sv
package scm_pkg;
  localparam int unsigned CLK_MHZ = 25;
  // Supply settling time before configuration restart is released
  localparam int unsigned SETTLE_US = 10000;
  localparam int unsigned SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
  // Half period of the unconfigured lamp flash
  localparam int unsigned FLASH_HALF_MS = 250;
  localparam int unsigned FLASH_HALF_CYCLES = FLASH_HALF_MS * 1000 * CLK_MHZ;

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_FLASH = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  localparam int CTRL_SOFT_RESTART = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SEQ_OFF = 2'b00,
    SEQ_SETTLE = 2'b01,
    SEQ_RUN = 2'b10
  } scm_seq_t;

  typedef struct packed {
    logic green;
    logic red;
  } scm_lamps_t;

  typedef struct packed {
    logic [21:0] zero;
    scm_seq_t seq;
    logic spare;
    logic restart_n;
    logic debug_sel;
    logic aux_n;
    logic ext_n;
    logic config_done;
    logic core_good;
    logic supplies_good;
  } scm_status_t;
endpackage

// ### scm_fpga_model.sv
`timescale 1ns/1ps
`default_nettype none
module scm_fpga_model #(
  parameter int unsigned LOAD_CYCLES = 20
) (
  input wire logic clock,
  input wire logic config_restart_n,
  output logic config_done,
  output scm_pkg::scm_lamps_t lamps
);
  import scm_pkg::*;
  int unsigned cnt;
  always_ff @(posedge clock) begin
    if (!config_restart_n) begin
      cnt <= 0;
      config_done <= 1'b0;
    end else if (cnt < LOAD_CYCLES) begin
      cnt <= cnt + 1;
    end else begin
      config_done <= 1'b1;
    end
  end
  assign lamps = '{green: 1'b1, red: 1'b0};
endmodule
`default_nettype wire

// ### module_system_controller_test.sv
`timescale 1ns/1ps
`default_nettype none
module module_system_controller_test;
  import scm_pkg::*;
  localparam int unsigned ST = 8;
  logic clock, rst_n, ext_n, aux_n, dbg, done, sg, rs_n, en33, jf, jc, lg, lr;
  logic [3:0] rails, awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  scm_lamps_t lamps;
  int err_count, n_checks;
  scm_controller #(.SETTLE_CYCLES(ST), .FLASH_HALF_RESET(32'h4)) dut (
    .clock(clock), .rst_n(rst_n), .rail_good(rails), .external_reset_n(ext_n),
    .aux_reset_n(aux_n), .debug_port_select(dbg), .fpga_config_done(done),
    .user_status_lamps(lamps), .supplies_good(sg), .fpga_config_restart_n(rs_n),
    .rail_3v3_enable(en33), .jtag_to_fpga_en(jf), .jtag_to_ctrl_en(jc),
    .status_lamp_green(lg), .status_lamp_red(lr), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  scm_fpga_model fpga (.clock(clock), .config_restart_n(rs_n), .config_done(done),
    .lamps(lamps));
  initial begin
    clock = 0;
    forever #20 clock = ~clock;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rsp);
    int n;
    n = 0;
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      n++;
    end while (!(bvalid && bready) && n < 50);
    rsp = bresp;
    if (!(bvalid && bready)) err_count++;
    bready <= 0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rsp);
    int n;
    n = 0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 0;
      n++;
    end while (!(rvalid && rready) && n < 50);
    v = rdata;
    rsp = rresp;
    if (!(rvalid && rready)) err_count++;
    rready <= 0;
  endtask
  task automatic t_flash();
    int tg;
    logic p;
    tg = 0;
    p = lg;
    repeat (12) begin
      cyc(1);
      chk(lr, lg);
      if (lg !== p) tg++;
      p = lg;
    end
    chk(tg >= 2, 1);
  endtask
  task automatic t_power();
    @(posedge clock);
    rails <= 4'hE;
    cyc(3);
    chk({sg, en33, rs_n}, 3'b000);
    @(posedge clock);
    rails <= 4'h1;
    cyc(2);
    chk({sg, en33, rs_n}, 3'b010);
    @(posedge clock);
    rails <= 4'hF;
    cyc(ST);
    chk({sg, rs_n}, 2'b10);
    cyc(3);
    chk(rs_n, 1);
    repeat (40) if (done !== 1) cyc(1);
    cyc(2);
    chk({lg, lr}, 2'b10);
  endtask
  task automatic t_reset(input int which);
    chk(sg, 1);
    @(posedge clock);
    if (which == 0) ext_n <= 0;
    else aux_n <= 0;
    cyc(1);
    chk(rs_n, 1);
    cyc(3);
    chk(rs_n, 0);
    chk({sg, en33}, 2'b11);
    @(posedge clock);
    ext_n <= 1;
    aux_n <= 1;
    repeat (20) if (rs_n !== 1) cyc(1);
    chk(rs_n, 1);
  endtask
  task automatic t_debug();
    @(posedge clock);
    dbg <= 1;
    cyc(4);
    chk({jf, jc}, 2'b01);
    @(posedge clock);
    dbg <= 0;
    cyc(4);
    chk({jf, jc}, 2'b10);
  endtask
  task automatic t_regs();
    wr(4'h4, 32'h0000_0007, r);
    chk(r, RESP_OKAY);
    rd(4'h4, d, r);
    chk(d, 32'h0000_0007);
    rd(4'hC, d, r);
    chk(r, RESP_SLVERR);
    chk(d, 32'h0);
    wr(4'hC, 32'hFFFF_FFFF, r);
    chk(r, RESP_SLVERR);
    wr(4'h0, 32'h0000_0001, r);
    cyc(2);
    chk(rs_n, 0);
    rd(4'h8, d, r);
    chk(d, 32'h0000_021B);
    wr(4'h0, 32'h0, r);
    chk(r, RESP_OKAY);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    rst_n = 0; rails = 4'h0; ext_n = 1; aux_n = 1; dbg = 0;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 0;
    awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    cyc(11);
    chk({rs_n, sg, en33, jf, jc}, 5'b00010);
    @(posedge clock);
    rst_n <= 1;
    t_flash();
    t_power();
    t_reset(0);
    t_reset(1);
    t_debug();
    t_regs();
    stop_test();
  end
  initial begin
    repeat (3000) @(posedge clock);
    err_count++;
    stop_test();
  end
endmodule
`default_nettype wire
